//--- pkg/rbt_pkg.sv
// Package for the registered bus transceiver: pin bundles, state records,
// register offsets, field positions and reset values.
// Assumes one 125 MHz clock domain and an AHB-Lite register slave.
package rbt_pkg;

    localparam int RBT_DW = 8;
    localparam int RBT_AW = 8;

    localparam logic [RBT_AW-1:0] RBT_CTRL_OFF = 8'h00;
    localparam logic [RBT_AW-1:0] RBT_STAT_OFF = 8'h04;

    // Control register field positions.
    localparam int RBT_CTRL_OUT_MODE = 0;
    localparam int RBT_CTRL_IN_MODE = 2;
    localparam int RBT_CTRL_RET = 4;
    localparam int RBT_CTRL_A_OE = 5;
    localparam int RBT_CTRL_B_EN = 6;
    localparam int RBT_CTRL_B_EN_N = 7;
    localparam int RBT_CTRL_SW_SRC = 8;
    localparam int RBT_CTRL_W = 9;
    localparam logic [RBT_CTRL_W-1:0] RBT_CTRL_RST = 9'h080;

    // Status register field positions.
    localparam int RBT_STAT_AB = 0;
    localparam int RBT_STAT_BA = 8;
    localparam int RBT_STAT_BLINE = 16;

    localparam logic [1:0] RBT_MODE_BUF = 2'h0;
    localparam logic [1:0] RBT_MODE_FF = 2'h1;
    localparam logic [1:0] RBT_MODE_LAT = 2'h2;

    typedef struct packed {
        logic b_en_n;
        logic b_en;
        logic a_oe;
        logic ret;
        logic [1:0] in_mode;
        logic [1:0] out_mode;
    } rbt_ctl_t;

    typedef struct packed {
        rbt_ctl_t ctl;
        logic clk_ab;
        logic clk_ba;
        logic [RBT_DW-1:0] a_in;
        logic [RBT_DW-1:0] b_in;
    } rbt_pin_t;

    typedef struct packed {
        logic [RBT_DW-1:0] q;
    } rbt_elem_st_t;

    typedef struct packed {
        rbt_pin_t sync1;
        rbt_pin_t sync2;
        logic clk_ab_prev;
        logic clk_ba_prev;
        logic [RBT_CTRL_W-1:0] ctrl;
        logic dp_wr;
        logic [RBT_AW-1:0] dp_addr;
        logic [31:0] hrdata;
        logic [RBT_DW-1:0] a_out;
        logic a_oe;
        logic [RBT_DW-1:0] b_out;
        logic [RBT_DW-1:0] b_oe;
    } rbt_top_st_t;

    localparam rbt_pin_t RBT_PIN_RST = '0;

endpackage

//--- logic/rbt_elem.sv
// One direction's logic element: inverting buffer, edge flip-flop or latch.
// Assumes the clock/latch enable has already been synchronised to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module rbt_elem
    import rbt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [1:0] mode,
    input wire logic le,
    input wire logic rise,
    input wire logic [RBT_DW-1:0] din,
    output logic [RBT_DW-1:0] dout
);

    rbt_elem_st_t s_q;
    rbt_elem_st_t s_d;

    // The stored value keeps loading whatever the port enables do.
    always_comb begin
        s_d = s_q;
        dout = s_q.q;
        unique casez (mode)
            2'b00: begin
                dout = ~din;
            end
            2'b01: begin
                if (rise) begin
                    s_d.q = ~din;
                end
            end
            2'b1?: begin
                if (le) begin
                    s_d.q = ~din;
                    dout = ~din;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_buf_invert: assert property (
        mode == RBT_MODE_BUF |-> dout == ~din)
        else $error("buffer mode output is not the inverted input");
    a_ff_capture: assert property (
        (mode == RBT_MODE_FF && rise) ##1 (mode == RBT_MODE_FF)
        |-> dout == ~$past(din))
        else $error("flip-flop did not capture on the clock rise");
    a_ff_hold: assert property (
        (mode == RBT_MODE_FF && !rise) ##1 (mode == RBT_MODE_FF)
        |-> $stable(dout))
        else $error("flip-flop changed without a clock rise");
    a_latch_hold: assert property (
        (mode[1] && !le) ##1 (mode[1] && !le) |-> $stable(dout))
        else $error("closed latch changed its output");
    a_latch_pass: assert property (
        mode[1] && le |-> dout == ~din)
        else $error("open latch does not pass the inverted input");

endmodule // rbt_elem
`default_nettype wire

//--- logic/rbt_xcvr.sv
// Eight-bit registered bus transceiver with an AHB-Lite control slave.
// Assumes all pins are asynchronous to ref_clk and the B lines are pulled up.
//
// Operation
// - Eight bits each way: split A in and out buses, one shared open-drain B.
// - Two mode bits per direction: 00 buffer, 01 flip-flop, 1X latch.
// - Buffer mode passes the inverted element input straight through.
// - Flip-flop mode captures the inverted input on its clock's rising edge.
// - Latch mode passes inverted input while enable high, holds while low.
// - Return path off: B-port data feeds the B-to-A element.
// - Return path on: the A-to-B element output feeds the B-to-A element.
// - A output floats while its enable is low, drives B-to-A result when high.
// - B port drives only with B enable high and its inverted enable low.
// - Both elements load or hold data whatever their output enables are.
`timescale 1ns/1ns
`default_nettype none
module rbt_xcvr
    import rbt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [RBT_DW-1:0] a_side_in,
    output logic [RBT_DW-1:0] a_side_out,
    output logic a_side_out_oe,
    input wire logic [RBT_DW-1:0] b_line_in,
    output logic [RBT_DW-1:0] b_line_out,
    output logic [RBT_DW-1:0] b_line_oe,
    input wire logic outbound_sel_hi,
    input wire logic outbound_sel_lo,
    input wire logic inbound_sel_hi,
    input wire logic inbound_sel_lo,
    input wire logic outbound_clk_le,
    input wire logic inbound_clk_le,
    input wire logic return_path_sel,
    input wire logic a_out_enable,
    input wire logic b_drive_enable,
    input wire logic b_drive_enable_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    rbt_top_st_t s_q;
    rbt_top_st_t s_d;
    rbt_pin_t pins;
    rbt_ctl_t eff;
    rbt_ctl_t sw_ctl;
    logic [RBT_DW-1:0] ab_res;
    logic [RBT_DW-1:0] ba_res;
    logic [RBT_DW-1:0] ba_din;
    logic rise_ab;
    logic rise_ba;
    logic addr_ok;
    logic [31:0] rd_val;
    logic hreadyout_q;
    logic hresp_q;

    // Every transceiver pin enters through two flops before any logic looks at it; the AHB inputs are used directly.
    always_comb begin
        pins.ctl.out_mode = {outbound_sel_hi, outbound_sel_lo};
        pins.ctl.in_mode = {inbound_sel_hi, inbound_sel_lo};
        pins.ctl.ret = return_path_sel;
        pins.ctl.a_oe = a_out_enable;
        pins.ctl.b_en = b_drive_enable;
        pins.ctl.b_en_n = b_drive_enable_n;
        pins.clk_ab = outbound_clk_le;
        pins.clk_ba = inbound_clk_le;
        pins.a_in = a_side_in;
        pins.b_in = b_line_in;
    end

    assign sw_ctl = s_q.ctrl[RBT_CTRL_B_EN_N:0];
    // Software may take the controls over from the pins, for bring-up.
    assign eff = s_q.ctrl[RBT_CTRL_SW_SRC] ? sw_ctl : s_q.sync2.ctl;
    assign rise_ab = s_q.sync2.clk_ab & ~s_q.clk_ab_prev;
    assign rise_ba = s_q.sync2.clk_ba & ~s_q.clk_ba_prev;
    assign ba_din = eff.ret ? ab_res : s_q.sync2.b_in;

    // Elements see no output enable at all, so they run regardless.
    rbt_elem u_ab (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .mode(eff.out_mode),
        .le(s_q.sync2.clk_ab),
        .rise(rise_ab),
        .din(s_q.sync2.a_in),
        .dout(ab_res)
    );

    rbt_elem u_ba (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .mode(eff.in_mode),
        .le(s_q.sync2.clk_ba),
        .rise(rise_ba),
        .din(ba_din),
        .dout(ba_res)
    );

    assign addr_ok = hsel & hready & htrans[1];

    always_comb begin
        rd_val = 32'h0000_0000;
        if (haddr[RBT_AW-1:0] == RBT_CTRL_OFF) begin
            rd_val[RBT_CTRL_W-1:0] = s_q.ctrl;
        end else if (haddr[RBT_AW-1:0] == RBT_STAT_OFF) begin
            rd_val[RBT_STAT_AB +: RBT_DW] = ab_res;
            rd_val[RBT_STAT_BA +: RBT_DW] = ba_res;
            rd_val[RBT_STAT_BLINE +: RBT_DW] = s_q.sync2.b_in;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.clk_ab_prev = s_q.sync2.clk_ab;
        s_d.clk_ba_prev = s_q.sync2.clk_ba;
        // Write data arrives one cycle after its address phase.
        if (s_q.dp_wr && s_q.dp_addr == RBT_CTRL_OFF) begin
            s_d.ctrl = hwdata[RBT_CTRL_W-1:0];
        end
        s_d.dp_wr = addr_ok & hwrite;
        s_d.dp_addr = haddr[RBT_AW-1:0];
        if (addr_ok && !hwrite) begin
            s_d.hrdata = rd_val;
        end
        // The A bus is a registered copy, so it trails the element by one.
        s_d.a_out = ba_res;
        s_d.a_oe = eff.a_oe;
        s_d.b_out = '0;
        if (eff.b_en && !eff.b_en_n) begin
            s_d.b_oe = ~ab_res;
        end else begin
            s_d.b_oe = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q.sync1 <= RBT_PIN_RST;
            s_q.sync2 <= RBT_PIN_RST;
            s_q.clk_ab_prev <= 1'b0;
            s_q.clk_ba_prev <= 1'b0;
            s_q.ctrl <= RBT_CTRL_RST;
            s_q.dp_wr <= 1'b0;
            s_q.dp_addr <= '0;
            s_q.hrdata <= 32'h0000_0000;
            s_q.a_out <= '0;
            s_q.a_oe <= 1'b0;
            s_q.b_out <= '0;
            s_q.b_oe <= '0;
            hreadyout_q <= 1'b0;
            hresp_q <= 1'b0;
        end else begin
            s_q <= s_d;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    assign a_side_out = s_q.a_out;
    assign a_side_out_oe = s_q.a_oe;
    assign b_line_out = s_q.b_out;
    assign b_line_oe = s_q.b_oe;
    assign hrdata = s_q.hrdata;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_pin_sync: assert property (
        ##2 1'b1 |-> s_q.sync2.a_in == $past(a_side_in, 2))
        else $error("A input not delayed by exactly two flops");
    a_bport_src: assert property (
        !eff.ret |-> ba_din == s_q.sync2.b_in)
        else $error("B-to-A element not fed from B port");
    a_loop_src: assert property (
        eff.ret |-> ba_din == ab_res)
        else $error("B-to-A element not fed from A-to-B result");
    a_aout_hiz: assert property (
        !eff.a_oe |=> !a_side_out_oe)
        else $error("A output driven while disabled");
    a_aout_data: assert property (
        eff.a_oe |=> a_side_out_oe && a_side_out == $past(ba_res))
        else $error("A output does not show the B-to-A result");
    a_b_release: assert property (
        (!eff.b_en || eff.b_en_n) |=> b_line_oe == '0)
        else $error("B port drives while inactive");
    a_b_drive: assert property (
        (eff.b_en && !eff.b_en_n) |=>
        b_line_oe == ~$past(ab_res) && b_line_out == '0)
        else $error("B port open-drain drive wrong");
    a_pin_to_aout: assert property (
        (!s_q.ctrl[RBT_CTRL_SW_SRC] && !a_out_enable) [*4]
        |-> !a_side_out_oe)
        else $error("A enable pin low for four cycles but output on");
    a_ctrl_write: assert property (
        s_q.dp_wr && s_q.dp_addr == RBT_CTRL_OFF |=>
        s_q.ctrl == $past(hwdata[RBT_CTRL_W-1:0]))
        else $error("control register write lost");
    a_ahb_ready: assert property (
        ##1 1'b1 |-> hreadyout && !hresp)
        else $error("slave stalled or errored");

    c_ff_capture: cover property (eff.out_mode == RBT_MODE_FF && rise_ab);
    c_loop_out: cover property (eff.ret && eff.a_oe ##1 a_side_out_oe);
    c_b_active: cover property (b_line_oe != '0);
    c_sw_write: cover property (s_q.dp_wr && s_q.dp_addr == RBT_CTRL_OFF);

endmodule // rbt_xcvr
`default_nettype wire

//--- tb/rbt_bplane.sv
// Backplane partner: open-drain B lines with pull-ups, shared with other cards.
// Assumes the bench plays the other cards by pulling lines low on ext_low.
`timescale 1ns/1ns
`default_nettype none
module rbt_bplane
    import rbt_pkg::*;
(
    input wire logic [RBT_DW-1:0] drv_val,
    input wire logic [RBT_DW-1:0] drv_oe,
    input wire logic [RBT_DW-1:0] ext_low,
    output logic [RBT_DW-1:0] line
);
    // A released line rises through its pull-up, so it never floats.
    assign line = ~((drv_oe & ~drv_val) | ext_low);
endmodule // rbt_bplane
`default_nettype wire

//--- tb/test_registered_bus_transceiver.sv
// Self-checking bench: random pin traffic with directed corners and AHB access.
// Assumes zero-wait AHB answers and a three-edge pin-to-output latency.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    $display("ERROR %s exp %h got %h", nm, e, g); n_errors++; end end
module test_registered_bus_transceiver
    import rbt_pkg::*;
;
    logic ref_clk = 1'h0, rstn = 1'h0;
    int n_errors = 0, tests_run = 0;
    logic [7:0] a_in = 8'h00, ext = 8'h00, p = 8'h00, r = 8'h00;
    logic [7:0] a_out, b_out, b_oe, b_lvl;
    logic [1:0] om = 2'h0, im = 2'h0, htrans = 2'h0;
    logic ret = 1'h0, aoe = 1'h0, ben = 1'h0, benn = 1'h1;
    logic cab = 1'h0, cba = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic hready, hreadyout, hresp, a_oe;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;

    rbt_xcvr u_dut (.ref_clk(ref_clk), .rstn(rstn), .a_side_in(a_in),
        .a_side_out(a_out), .a_side_out_oe(a_oe), .b_line_in(b_lvl),
        .b_line_out(b_out), .b_line_oe(b_oe), .outbound_sel_hi(om[1]),
        .outbound_sel_lo(om[0]), .inbound_sel_hi(im[1]),
        .inbound_sel_lo(im[0]), .outbound_clk_le(cab),
        .inbound_clk_le(cba), .return_path_sel(ret), .a_out_enable(aoe),
        .b_drive_enable(ben), .b_drive_enable_n(benn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));
    rbt_bplane u_bp (.drv_val(b_out), .drv_oe(b_oe), .ext_low(ext),
        .line(b_lvl));
    assign hready = hreadyout;

    function automatic logic [7:0] oe_f();
        return (ben && !benn) ? ~p : 8'h00;
    endfunction
    function automatic logic [7:0] lvl_f();
        return ~(oe_f() | ext);
    endfunction
    function automatic logic [7:0] din_f();
        return ret ? p : lvl_f();
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic ahb(input logic wr, input logic [31:0] ad, wd);
        int k = 0;
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= wr;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hready !== 1'h1 && k < 50);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wd;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hready !== 1'h1 && k < 100);
        rd = hrdata;
    endtask

    task automatic chk_all();
        `CHK("b_line_oe", oe_f(), b_oe)
        `CHK("b_line_out", 8'h00, b_out)
        `CHK("a_side_out_oe", aoe, a_oe)
        if (aoe)
            `CHK("a_side_out", r, a_out)
        ahb(1'h0, 32'h4, 32'h0);
        `CHK("status", {8'h00, lvl_f(), r, p}, rd)
        `CHK("hresp", 1'h0, hresp)
    endtask

    // The model captures at the rise; data was settled well before it.
    task automatic pulse(input logic ab);
        if (ab) begin
            cab <= 1'h1;
            p = ~a_in;
        end else begin
            cba <= 1'h1;
            r = ~din_f();
        end
        tick(3);
        cab <= 1'h0;
        cba <= 1'h0;
        tick(8);
    endtask

    // Twelve edges cover two chained three-edge paths with margin.
    task automatic settle();
        tick(12);
        if (om == 2'h0) p = ~a_in;
        if (im == 2'h0) r = ~din_f();
    endtask

    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    // About seventeen hundred edges are needed; this leaves ample margin.
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h7c375ee7));
        tick(2);
        rstn <= 1'h1;
        tick(2);
        ahb(1'h1, 32'h0c, 32'h1ff);
        ahb(1'h0, 32'h0, 32'h0);
        `CHK("ctrl reset", {23'h0, RBT_CTRL_RST}, rd)
        ahb(1'h0, 32'h08, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        a_in <= 8'h5a;
        ahb(1'h1, 32'h0, 32'h160);
        ahb(1'h0, 32'h0, 32'h0);
        `CHK("ctrl", 32'h160, rd)
        tick(8);
        `CHK("sw b_line_oe", 8'h5a, b_oe)
        ahb(1'h1, 32'h0, 32'h080);
        om <= 2'h2;
        im <= 2'h3;
        ben <= 1'h1;
        benn <= 1'h0;
        aoe <= 1'h1;
        cab <= 1'h1;
        cba <= 1'h1;
        a_in <= 8'hc3;
        tick(12);
        p = ~a_in;
        r = ~din_f();
        chk_all();
        cab <= 1'h0;
        cba <= 1'h0;
        tick(4);
        a_in <= 8'h3c;
        tick(12);
        chk_all();
        for (int i = 0; i < 40; i++) begin
            om <= 2'($urandom);
            im <= 2'($urandom);
            {ret, aoe, ben, benn} <= 4'($urandom);
            a_in <= 8'($urandom);
            ext <= (i % 4 == 0) ? 8'($urandom) : 8'h00;
            tick(4);
            pulse(1'h1);
            pulse(1'h0);
            a_in <= 8'($urandom);
            settle();
            chk_all();
        end
        wrap_up();
    end
endmodule // test_registered_bus_transceiver
`default_nettype wire
